// >>> verilog/core_status_pkg.sv
// Constants, field positions and enumerations for the core status, option,
// reset-cause and program counter block.
// Assumes byte addressed AXI4-Lite words and a 13-bit program counter.
//
// What this block does
// [RULE1] Flag-setting op to status keeps flags computed
// [RULE2] Expiry and sleep flags ignore all writes
// [RULE3] Bank bits form direct and indirect addresses
// [RULE4] Expiry flag: set on clear/sleep, cleared by timeout
// [RULE5] Sleep flag: set on clear, cleared by sleep
// [RULE6] Zero flag follows result equal zero
// [RULE7] Nibble flag is carry out of bit 3
// [RULE8] Carry flag is carry out of bit 7
// [RULE9] Subtract adds complement; rotates load carry
// [RULE10] Option bit 7 disables port B pull-ups
// [RULE11] Option bit 6 picks external interrupt edge
// [RULE12] Option bit 5 picks timer 0 clock source
// [RULE13] Option bit 4 picks timer 0 pin edge
// [RULE14] Option bit 3 gives prescaler to watchdog
// [RULE15] Ratio n: timer 2^(n+1), watchdog 2^n
// [RULE16] Power-on reset clears flag; software sets it
// [RULE17] Brown-out clears flag; upper bits read zero
// [RULE18] Low-byte write loads upper bits from latch
// [RULE19] Call and jump take page from latch
// [RULE20] Every reset but the watchdog and interrupt wakes clears the program counter
// [RULE21] Eight-deep stack pushes calls, pops returns
// [RULE22] Stack wraps around with no overflow flags
// [RULE23] Reset and interrupt wakes from sleep leave expiry set, sleep clear
package core_status_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_OPTION = 8'h04;
  localparam logic [7:0] OFS_CAUSE  = 8'h08;
  localparam logic [7:0] OFS_PCLOW  = 8'h0c;
  localparam logic [7:0] OFS_LATCH  = 8'h10;
  localparam logic [7:0] OFS_PCFULL = 8'h14;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int ST_IBS = 7;
  localparam int ST_EXP = 4;
  localparam int ST_SLP = 3;
  localparam int ST_Z   = 2;
  localparam int ST_NIB = 1;
  localparam int ST_C   = 0;
  localparam int OP_PUD = 7;
  localparam int OP_IED = 6;
  localparam int OP_TCS = 5;
  localparam int OP_TSE = 4;
  localparam int OP_OWN = 3;
  localparam int PC_POR = 1;
  localparam int PC_BRN = 0;
  localparam int PC_W   = 13;
  localparam int PAGE_W = 11;
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [7:0]  OPTION_RST = 8'hff;
  localparam logic [1:0]  CAUSE_RST  = 2'h0;
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_LOGIC, ALU_ROTL, ALU_ROTR
  } alu_kind_t;
  typedef enum logic [2:0] {
    PC_STEP, PC_JUMP, PC_CALL, PC_RET, PC_IRQ
  } pc_op_t;
  typedef enum logic [2:0] {
    RK_POR, RK_BROWN, RK_EXT_RUN, RK_EXT_SLEEP,
    RK_DOG_RESET, RK_DOG_WAKE, RK_INT_WAKE
  } rst_kind_t;

endpackage

// >>> verilog/core_status_pc_stack.sv
// Status, option and reset-cause registers, program counter with page latch
// and circular return stack of a small 8-bit core, with an AXI4-Lite slave.
// Assumes the core sequencer sends one-cycle strobes synchronous to aclk.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module core_status_pc_stack #(
  parameter int STACK_DEPTH = 8
) (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // ALU operation strobe
  input  wire logic        alu_valid,
  input  wire logic [2:0]  alu_kind,
  input  wire logic [7:0]  alu_a,
  input  wire logic [7:0]  alu_b,
  input  wire logic        alu_dest_status,
  output logic [7:0]       alu_result,
  // Program flow strobe
  input  wire logic        pc_valid,
  input  wire logic [2:0]  pc_op,
  input  wire logic [10:0] pc_target,
  output logic [12:0]      pc_out,
  // Reset and sleep events
  input  wire logic        rst_valid,
  input  wire logic [2:0]  rst_kind,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        sleep_instr,
  // Address formation
  input  wire logic [6:0]  file_addr,
  input  wire logic [7:0]  fsr,
  output logic [8:0]       direct_addr,
  output logic [8:0]       indirect_addr,
  // Pins and peripheral controls
  input  wire logic [7:0]  weak_pullup_enables,
  output logic [7:0]       pullup_en,
  input  wire logic        external_irq_pin,
  output logic             ext_irq_pulse,
  input  wire logic        timer0_ext_clock_pin,
  output logic             timer0_inc,
  output logic [3:0]       timer0_div_log2,
  output logic [3:0]       watchdog_div_log2
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]  status_q;
  logic [7:0]  option_q;
  logic [1:0]  cause_q;
  logic [4:0]  latch_q;
  logic [12:0] pc_q;
  logic [12:0] stack_q [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH)-1:0] sp_q;
  logic        aw_full_q, w_full_q;
  logic [7:0]  aw_addr_q;
  logic [7:0]  w_data_q;
  logic        w_lane_q;
  logic        irq_pin_q, t0_pin_q;

  core_status_pkg::alu_kind_t akind;
  core_status_pkg::pc_op_t    pop;
  core_status_pkg::rst_kind_t rkind;
  assign akind = core_status_pkg::alu_kind_t'(alu_kind);
  assign pop   = core_status_pkg::pc_op_t'(pc_op);
  assign rkind = core_status_pkg::rst_kind_t'(rst_kind);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Add or subtract; returns {carry, nibble carry, result}
  function automatic logic [9:0] add_sub(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       sub);
    logic [7:0] bx;
    logic [8:0] s;
    logic [4:0] n;
    bx = sub ? ~b : b;                         // [RULE9]
    s  = {1'b0, a} + {1'b0, bx} + {8'h00, sub};
    n  = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, sub};
    return {s[8], n[4], s[7:0]};               // [RULE7] [RULE8]
  endfunction

  function automatic logic hit(input logic [7:0] a);
    return a == core_status_pkg::OFS_STATUS ||
           a == core_status_pkg::OFS_OPTION ||
           a == core_status_pkg::OFS_CAUSE  ||
           a == core_status_pkg::OFS_PCLOW  ||
           a == core_status_pkg::OFS_LATCH  ||
           a == core_status_pkg::OFS_PCFULL;
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic do_wr;
  logic wr_status, wr_option, wr_cause, wr_pclow, wr_latch;
  assign do_wr     = aw_full_q && w_full_q && !bvalid && w_lane_q;
  assign wr_status = do_wr && aw_addr_q == core_status_pkg::OFS_STATUS;
  assign wr_option = do_wr && aw_addr_q == core_status_pkg::OFS_OPTION;
  assign wr_cause  = do_wr && aw_addr_q == core_status_pkg::OFS_CAUSE;
  assign wr_pclow  = do_wr && aw_addr_q == core_status_pkg::OFS_PCLOW;
  assign wr_latch  = do_wr && aw_addr_q == core_status_pkg::OFS_LATCH;

  // Address and data are held separately, so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= core_status_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {awaddr[7:2], 2'b00};
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        w_data_q <= wdata[7:0];
        w_lane_q <= 1'b1;
        wready   <= 1'b0;
        if (!wstrb[0]) begin
          w_lane_q <= 1'b0;                    // Lane 0 off: no store
        end
      end
      if (aw_full_q && w_full_q && !bvalid) begin
        bvalid    <= 1'b1;
        bresp     <= hit(aw_addr_q) ? core_status_pkg::RESP_OKAY
                                    : core_status_pkg::RESP_SLVERR;
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  // One cycle to answer; upper bits and reserved fields read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= core_status_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= hit({araddr[7:2], 2'b00}) ? core_status_pkg::RESP_OKAY
                                             : core_status_pkg::RESP_SLVERR;
        case ({araddr[7:2], 2'b00})
          core_status_pkg::OFS_STATUS: rdata <= {24'h0, status_q};
          core_status_pkg::OFS_OPTION: rdata <= {24'h0, option_q};
          core_status_pkg::OFS_CAUSE:  rdata <= {30'h0, cause_q}; // [RULE17]
          core_status_pkg::OFS_PCLOW:  rdata <= {24'h0, pc_q[7:0]};
          core_status_pkg::OFS_LATCH:  rdata <= {27'h0, latch_q};
          core_status_pkg::OFS_PCFULL: rdata <= {19'h0, pc_q};
          default:                     rdata <= 32'h0000_0000;
        endcase
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // ALU and status register
  // ---------------------------------------------------------------
  logic [9:0] sum;
  logic [7:0] res;
  logic       c_new, dc_new, arith;
  always_comb begin
    sum    = add_sub(alu_a, alu_b, akind == core_status_pkg::ALU_SUB);
    arith  = akind == core_status_pkg::ALU_ADD ||
             akind == core_status_pkg::ALU_SUB;
    res    = alu_a;
    c_new  = status_q[core_status_pkg::ST_C];
    dc_new = status_q[core_status_pkg::ST_NIB];
    case (akind)
      core_status_pkg::ALU_ADD, core_status_pkg::ALU_SUB: begin
        res    = sum[7:0];
        c_new  = sum[9];
        dc_new = sum[8];
      end
      core_status_pkg::ALU_ROTL: begin
        res   = {alu_a[6:0], status_q[core_status_pkg::ST_C]};
        c_new = alu_a[7];                      // [RULE9]
      end
      core_status_pkg::ALU_ROTR: begin
        res   = {status_q[core_status_pkg::ST_C], alu_a[7:1]};
        c_new = alu_a[0];                      // [RULE9]
      end
      default: res = alu_a & alu_b;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alu_result <= 8'h00;
    end else if (clk_en && alu_valid) begin
      alu_result <= res;
    end
  end

  // Reset events outrank ALU updates, which outrank bus writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= core_status_pkg::STATUS_RST;
    end else if (clk_en) begin
      if (wr_status) begin
        status_q[7:5] <= w_data_q[7:5];        // [RULE2]
        status_q[2:0] <= w_data_q[2:0];
      end
      if (alu_valid) begin
        if (alu_dest_status) begin
          status_q[7:5] <= res[7:5];           // [RULE1]
        end
        status_q[core_status_pkg::ST_Z] <= res == 8'h00; // [RULE6]
        if (arith || akind == core_status_pkg::ALU_ROTL ||
            akind == core_status_pkg::ALU_ROTR) begin
          status_q[core_status_pkg::ST_C] <= c_new; // [RULE8]
        end
        if (arith) begin
          status_q[core_status_pkg::ST_NIB] <= dc_new; // [RULE7]
        end
      end
      if (watchdog_clear_instr) begin
        status_q[core_status_pkg::ST_EXP] <= 1'b1; // [RULE4]
        status_q[core_status_pkg::ST_SLP] <= 1'b1; // [RULE5]
      end
      if (sleep_instr) begin
        status_q[core_status_pkg::ST_EXP] <= 1'b1; // [RULE4]
        status_q[core_status_pkg::ST_SLP] <= 1'b0; // [RULE5]
      end
      if (rst_valid) begin
        case (rkind)
          core_status_pkg::RK_POR, core_status_pkg::RK_BROWN: begin
            status_q[7:3] <= 5'b00011;         // [RULE4] [RULE5]
          end
          core_status_pkg::RK_EXT_RUN: status_q[7:5] <= 3'b000;
          core_status_pkg::RK_EXT_SLEEP: begin
            status_q[7:3] <= 5'b00010;         // [RULE23]
          end
          core_status_pkg::RK_DOG_RESET: begin
            status_q[7:3] <= 5'b00001;         // [RULE4]
          end
          core_status_pkg::RK_DOG_WAKE: begin
            status_q[4:3] <= 2'b00;            // [RULE4]
          end
          core_status_pkg::RK_INT_WAKE: begin
            status_q[4:3] <= 2'b10;            // [RULE23]
          end
          default: status_q <= status_q;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Option and reset-cause registers
  // ---------------------------------------------------------------
  logic hard_rst;
  assign hard_rst = rst_valid && rkind != core_status_pkg::RK_DOG_WAKE &&
                    rkind != core_status_pkg::RK_INT_WAKE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_q <= core_status_pkg::OPTION_RST;
    end else if (clk_en) begin
      if (hard_rst) begin
        option_q <= core_status_pkg::OPTION_RST;
      end else if (wr_option) begin
        option_q <= w_data_q;
      end
    end
  end

  // A reset event in the same cycle as a software set still clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q <= core_status_pkg::CAUSE_RST;
    end else if (clk_en) begin
      if (wr_cause) begin
        cause_q <= w_data_q[1:0];              // [RULE16] [RULE17]
      end
      if (rst_valid && rkind == core_status_pkg::RK_POR) begin
        cause_q[core_status_pkg::PC_POR] <= 1'b0; // [RULE16]
      end
      if (rst_valid && rkind == core_status_pkg::RK_BROWN) begin
        cause_q[core_status_pkg::PC_BRN] <= 1'b0; // [RULE17]
      end
    end
  end

  // ---------------------------------------------------------------
  // Program counter, page latch and return stack
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= 5'h00;
    end else if (clk_en && wr_latch) begin
      latch_q <= w_data_q[4:0];                // Untouched by push/pop
    end
  end

  // Pointer wraps silently; deep recursion loses the oldest entries
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= 13'h0000;
      sp_q <= '0;
    end else if (clk_en) begin
      if (hard_rst) begin
        pc_q <= 13'h0000;                      // [RULE20]
      end else if (wr_pclow) begin
        pc_q <= {latch_q, w_data_q};           // [RULE18]
      end else if (pc_valid) begin
        case (pop)
          core_status_pkg::PC_STEP: pc_q <= pc_q + 13'h0001;
          core_status_pkg::PC_JUMP: pc_q <= {latch_q[4:3], pc_target};
          core_status_pkg::PC_CALL: begin
            stack_q[sp_q] <= pc_q;             // [RULE21]
            sp_q          <= sp_q + 1'b1;      // [RULE22]
            pc_q          <= {latch_q[4:3], pc_target}; // [RULE19]
          end
          core_status_pkg::PC_IRQ: begin
            stack_q[sp_q] <= pc_q;             // [RULE21]
            sp_q          <= sp_q + 1'b1;      // [RULE22]
            pc_q          <= core_status_pkg::INT_VECTOR;
          end
          core_status_pkg::PC_RET: begin
            pc_q <= stack_q[sp_q - 1'b1];      // [RULE21]
            sp_q <= sp_q - 1'b1;               // [RULE22]
          end
          default: pc_q <= pc_q;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_out <= 13'h0000;
    end else if (clk_en) begin
      pc_out <= pc_q;
    end
  end

  // ---------------------------------------------------------------
  // Bank addressing and option-driven controls
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direct_addr       <= 9'h000;
      indirect_addr     <= 9'h000;
      pullup_en         <= 8'h00;
      timer0_div_log2   <= 4'h0;
      watchdog_div_log2 <= 4'h0;
    end else if (clk_en) begin
      direct_addr   <= {status_q[6:5], file_addr};          // [RULE3]
      indirect_addr <= {status_q[core_status_pkg::ST_IBS], fsr}; // [RULE3]
      pullup_en     <= option_q[core_status_pkg::OP_PUD] ? 8'h00
                       : weak_pullup_enables;               // [RULE10]
      if (option_q[core_status_pkg::OP_OWN]) begin
        timer0_div_log2   <= 4'h0;                          // [RULE14]
        watchdog_div_log2 <= {1'b0, option_q[2:0]};         // [RULE15]
      end else begin
        timer0_div_log2   <= {1'b0, option_q[2:0]} + 4'h1;  // [RULE15]
        watchdog_div_log2 <= 4'h0;                          // [RULE14]
      end
    end
  end

  // Pin edges are found against one stored sample of each pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pin_q     <= 1'b0;
      t0_pin_q      <= 1'b0;
      ext_irq_pulse <= 1'b0;
      timer0_inc    <= 1'b0;
    end else if (clk_en) begin
      irq_pin_q <= external_irq_pin;
      t0_pin_q  <= timer0_ext_clock_pin;
      ext_irq_pulse <= option_q[core_status_pkg::OP_IED]
                       ? (external_irq_pin && !irq_pin_q)
                       : (!external_irq_pin && irq_pin_q);  // [RULE11]
      if (option_q[core_status_pkg::OP_TCS]) begin
        timer0_inc <= option_q[core_status_pkg::OP_TSE]
                      ? (!timer0_ext_clock_pin && t0_pin_q)
                      : (timer0_ext_clock_pin && !t0_pin_q); // [RULE13]
      end else begin
        timer0_inc <= 1'b1;                    // [RULE12]
      end
    end
  end

endmodule // core_status_pc_stack

// >>> tb/core_status_chk.sv
// Checker for core_status_pc_stack: addresses, page loads, pc clear and
// option driven outputs. Bound to the top module, sees its ports only.
`timescale 1ns/100ps
module core_status_chk (
  // Clock, reset, enable
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  // Program flow
  input wire logic        pc_valid,
  input wire logic [2:0]  pc_op,
  input wire logic [10:0] pc_target,
  input wire logic [12:0] pc_out,
  input wire logic        rst_valid,
  input wire logic [2:0]  rst_kind,
  // Addresses and pins
  input wire logic [6:0]  file_addr,
  input wire logic [7:0]  fsr,
  input wire logic [8:0]  direct_addr,
  input wire logic [8:0]  indirect_addr,
  input wire logic [7:0]  weak_pullup_enables,
  input wire logic [7:0]  pullup_en,
  input wire logic        external_irq_pin,
  input wire logic        ext_irq_pulse,
  input wire logic [3:0]  timer0_div_log2,
  input wire logic [3:0]  watchdog_div_log2
);
  // A low clock enable freezes all state, so checks pause with it
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !clk_en);
  // -----------------------------------------------------------
  // Properties
  // -----------------------------------------------------------
  property p_direct;
    $past(aresetn) |-> direct_addr[6:0] == $past(file_addr);
  endproperty
  a_direct: assert property (p_direct) else $error("direct addr");
  property p_indirect;
    $past(aresetn) |-> indirect_addr[7:0] == $past(fsr);
  endproperty
  a_indirect: assert property (p_indirect) else $error("ind addr");
  property p_page;
    pc_valid && pc_op inside {3'h1, 3'h2} && !rst_valid
      |=> ##1 pc_out[10:0] == $past(pc_target, 2);
  endproperty
  a_page: assert property (p_page) else $error("page target");
  property p_pc_clear;
    rst_valid && rst_kind <= 3'h4 |=> ##1 pc_out == 13'h0000;
  endproperty
  a_pc_clear: assert property (p_pc_clear) else $error("pc clear");
  property p_pullup;
    pullup_en == 8'h00 || pullup_en == $past(weak_pullup_enables);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up");
  property p_share;
    timer0_div_log2 == 4'h0 || watchdog_div_log2 == 4'h0;
  endproperty
  a_share: assert property (p_share) else $error("prescaler");
  property p_range;
    timer0_div_log2 <= 4'h8 && watchdog_div_log2 <= 4'h7;
  endproperty
  a_range: assert property (p_range) else $error("ratio range");
  // A pulse needs the pin to differ across the two edges before it
  property p_irq_edge;
    ext_irq_pulse |-> $past(external_irq_pin) != $past(external_irq_pin, 2);
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("irq edge");
endmodule // core_status_chk

bind core_status_pc_stack core_status_chk u_core_status_chk (.*);

// >>> tb/tb_core_status_pc_stack.sv
// Bench for core_status_pc_stack: bus master, core strobes and pins,
// checked against an integer model. Assumes package and design compiled.
`timescale 1ns/100ps
module tb_core_status_pc_stack;
  // -----------------------------------------------------------
  // Signals and model state
  // -----------------------------------------------------------
  logic        aclk = '0, aresetn = '0, clk_en = 1'h1, bready = 1'h1;
  logic        rready = 1'h1, awvalid = '0, wvalid = '0, arvalid = '0;
  logic        alu_valid = '0, alu_dest_status = '0, pc_valid = '0;
  logic        rst_valid = '0, watchdog_clear_instr = '0, sleep_instr = '0;
  logic        external_irq_pin = '0, timer0_ext_clock_pin = '0, timer0_inc;
  logic [7:0]  awaddr = '0, araddr = '0, alu_a = '0, alu_b = '0, fsr = '0;
  logic [7:0]  weak_pullup_enables = '0, alu_result, pullup_en;
  logic [31:0] wdata = '0, rdata, rv;
  logic [3:0]  wstrb = 4'h1, timer0_div_log2, watchdog_div_log2;
  logic [2:0]  alu_kind = '0, pc_op = '0, rst_kind = '0;
  logic [10:0] pc_target = '0;
  logic [6:0]  file_addr = '0;
  logic        awready, wready, bvalid, arready, rvalid, ext_irq_pulse;
  logic [1:0]  bresp, rresp, rr;
  logic [12:0] pc_out;
  logic [8:0]  direct_addr, indirect_addr;
  int error_cnt = 0, comparisons = 0, seed = 7, ni = 0, nt = 0, sp = 0;
  int st, pc, lat, i, j, k, a, b, bx, r, c, dc, o, t, n0, t0;
  int stk[8];
  int evk[7] = '{8, 9, 4, 5, 6, 3, 2};
  int evx[7] = '{16, 24, 8, 0, 16, 16, 16};

  core_status_pc_stack u_core_status_pc_stack (.*);

  // Clock, pulse counters and free-running address inputs
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    ni <= ni + ext_irq_pulse;
    nt <= nt + timer0_inc;
    file_addr <= 7'($random(seed));
    fsr <= 8'($random(seed));
  end
  // -----------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Each channel is released at the edge where it was taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    chk(bresp, core_status_pkg::RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] ad);
    araddr <= ad;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rv = rdata;
    rr = rresp;
  endtask
  // Codes 0..6 are reset kinds, 8 a sleep, 9 a watchdog clear
  task automatic ev(input int e);
    rst_valid <= e < 8;
    rst_kind <= 3'(e);
    sleep_instr <= e == 8;
    watchdog_clear_instr <= e == 9;
    @(posedge aclk);
    {rst_valid, sleep_instr, watchdog_clear_instr} <= 3'h0;
    @(posedge aclk);
  endtask
  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(8'h18);
    chk(rr, core_status_pkg::RESP_SLVERR);
    st = 24;
    // Random operations; the model keeps carry state between them
    for (i = 0; i < 40; i++) begin
      k = i % 5;
      a = $random(seed) & 255;
      b = $random(seed) & 255;
      bx = (k == 1) ? 255 - b : b;
      c = st % 2;
      dc = st / 2 % 2;
      r = (k == 2) ? a & b : (k == 3) ? a * 2 + c :
          (k == 4) ? c * 128 + a / 2 : a + bx + k;
      if (k < 2)
        dc = (a % 16 + bx % 16 + k) > 15;
      c = (k < 2) ? r / 256 : (k == 3) ? a / 128 : (k == 4) ? a % 2 : c;
      r = r % 256;
      st = (st & 24) | (i[3] ? r & 224 : st & 224) | (r == 0) * 4 | dc * 2 | c;
      alu_dest_status <= i[3];
      alu_kind <= 3'(k);
      alu_a <= 8'(a);
      alu_b <= 8'(b);
      alu_valid <= 1'h1;
      @(posedge aclk);
      alu_valid <= 1'h0;
      @(posedge aclk);
      chk(alu_result, r);
      rd(core_status_pkg::OFS_STATUS);
      chk(rv, st);
      chk({indirect_addr[8], direct_addr[8:7]}, st / 32);
    end
    wr(core_status_pkg::OFS_STATUS, 32'h0);
    rd(core_status_pkg::OFS_STATUS);
    chk(rv, 32'h18);
    for (i = 0; i < 7; i++) begin
      ev(evk[i]);
      rd(core_status_pkg::OFS_STATUS);
      chk(rv & 24, evx[i]);
    end
    wr(core_status_pkg::OFS_CAUSE, 32'hff);
    ev(1);
    rd(core_status_pkg::OFS_CAUSE);
    chk(rv, 32'h2);
    ev(0);
    rd(core_status_pkg::OFS_CAUSE);
    chk(rv & 2, 0);
    // Every combination of the option control bits, both pin edges
    for (i = 0; i < 32; i++) begin
      o = i * 8 + ($random(seed) & 7);
      weak_pullup_enables <= 8'($random(seed));
      wr(core_status_pkg::OFS_OPTION, o);
      rd(core_status_pkg::OFS_OPTION);
      chk(rv, o);
      chk(pullup_en, o[7] ? 0 : weak_pullup_enables);
      chk(timer0_div_log2, o[3] ? 0 : o % 8 + 1);
      chk(watchdog_div_log2, o[3] ? o % 8 : 0);
      for (j = 0; j < 2; j++) begin
        external_irq_pin <= j == 0;
        timer0_ext_clock_pin <= j == 0;
        n0 = ni;
        t0 = nt;
        repeat (6) @(posedge aclk);
        chk(ni - n0, o[6] ^ j);
        chk(nt - t0, o[5] ? o[4] == j : 6);
      end
    end
    lat = 27;
    wr(core_status_pkg::OFS_LATCH, lat);
    wstrb <= 4'h0;
    wr(core_status_pkg::OFS_LATCH, 32'h0);
    wstrb <= 4'h1;
    wr(core_status_pkg::OFS_PCLOW, 32'h34);
    pc = lat * 256 + 52;
    rd(core_status_pkg::OFS_PCFULL);
    chk(rv, pc);
    // Ten pushes wrap the stack, ten pops follow, then steps and jumps
    for (i = 0; i < 24; i++) begin
      k = i < 10 ? (i % 4 == 3 ? 4 : 2) : i < 20 ? 3 : i % 2;
      t = $random(seed) & 2047;
      if (k == 2 || k == 4) begin
        stk[sp] = pc;
        sp = (sp + 1) % 8;
      end
      if (k == 3) begin
        sp = (sp + 7) % 8;
        pc = stk[sp];
      end
      if (k != 3)
        pc = k == 0 ? (pc + 1) % 8192 : k < 3 ? lat / 8 * 2048 + t
             : core_status_pkg::INT_VECTOR;
      pc_op <= 3'(k);
      pc_target <= 11'(t);
      pc_valid <= 1'h1;
      @(posedge aclk);
      pc_valid <= 1'h0;
      repeat (2) @(posedge aclk);
      chk(pc_out, pc);
    end
    rd(core_status_pkg::OFS_LATCH);
    chk(rv, lat);
    ev(2);
    rd(core_status_pkg::OFS_PCFULL);
    chk(rv, 0);
    end_of_test();
  end
  // Watchdog: the run needs well under 5000 cycles
  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end
endmodule // tb_core_status_pc_stack
